// ---- dv/icfo_host.sv ----
// icfo_host: host model driving the configuration port
`timescale 1ns/1ps
module icfo_host
  import icfo_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // configuration port
  output icfo_req_t       req_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  int unsigned gap_max = 0; // idle cycles allowed before a request
  initial req_o = '0;
  ////////////////////////////////////////////////////////////
  // one request held across exactly one taking edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    repeat ($urandom_range(gap_max)) @(posedge clk_i);
    @(posedge clk_i) #1;
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i) #1;
    q = rvalid_i ? rdata_i : 8'hXX; // answer stands one cycle only
    req_o.wr = 1'b0;
    req_o.rd = 1'b0;
    req_o.wdata = ~d; // released data never shows the last byte
  endtask : xfer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask : rd
  // indexed threshold: index, then high byte, then low byte
  task automatic ac_thr(input logic [15:0] v);
    wr(A_IDX, 8'h80);
    wr(A_ATHH, v[15:8]);
    wr(A_ATHL, v[7:0]);
  endtask : ac_thr
  // the register takes a write as a difference, so write both readbacks xor wanted
  task automatic ddr_set(input logic [7:0] v);
    logic [7:0] b;
    logic [7:0] s;
    rd(A_DDR, b);
    rd(A_CFGS, s);
    wr(A_DDR, b ^ s ^ v);
  endtask : ddr_set
  // a fresh 0 then 1 is needed for every advance
  task automatic advance();
    wr(A_SLIP, 8'h00);
    wr(A_SLIP, 8'h01);
  endtask : advance
endmodule : icfo_host

// ---- dv/icfo_regs_tb.sv ----
// icfo_regs_tb: self-checking bench of the freeze meters and config bank
`timescale 1ns/1ps
module icfo_regs_tb
  import icfo_pkg::*;
();
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0, corr_run_i = 1'b0;
  logic smp_vld_i = 1'b1, smode = 1'b0, ph = 1'b0, oc_q = 1'b0;
  logic signed [7:0] smp_i = 8'h00, samp_a = 8'h00; // sample and its amplitude
  logic [1:0] dpin = 2'h0, cpin = 2'h0; // strap pins
  icfo_req_t req;
  logic [7:0] rdata, trim;
  logic rvalid, offs, gain, skew, rms_h, ac_h, ild, oclk, ddr, dll;
  icfo_init_t ival;
  icfo_drive_t drv;
  icfo_coding_t cod;
  int n_mismatch = 0, checked = 0, cyc = 0, gapc = 0, n_short = 0, n_odd = 0;
  icfo_regs uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
    .cfg_req_i(req), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .smp_vld_i(smp_vld_i),
    .smp_i(smp_i), .corr_run_i(corr_run_i), .offset_upd_en_o(offs), .gain_upd_en_o(gain),
    .skew_upd_en_o(skew), .rms_hold_o(rms_h), .ac_hold_o(ac_h), .init_load_o(ild),
    .init_val_o(ival), .skew_trim_o(trim), .out_clk_o(oclk), .drive_select_pin_i(dpin),
    .coding_select_pin_i(cpin), .drive_mode_o(drv), .coding_o(cod), .ddr_en_o(ddr),
    .dll_slow_o(dll));
  icfo_host host (.clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
  ////////////////////////////////////////////////////////////
  always #4 sys_clk_i = ~sys_clk_i;
  // samples: constant, or alternating sign each cycle
  always @(posedge sys_clk_i) begin
    #1;
    ph <= ~ph;
    smp_i <= (smode && ph) ? -samp_a : samp_a;
  end
  // output clock rise spacing, plus the hang limit
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    oc_q <= oclk;
    gapc <= (oclk && !oc_q) ? 1 : gapc + 1;
    if (oclk && !oc_q && gapc == 3) n_short <= n_short + 1;
    if (oclk && !oc_q && gapc != 3 && gapc != 4) n_odd <= n_odd + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  // one-hot field codes override; straps 2 and 3 both pick the third option
  function automatic logic [1:0] sel(input logic [2:0] f, input logic [1:0] p);
    return f == 3'h1 ? 2'h0 : f == 3'h2 ? 2'h1 : f == 3'h4 ? 2'h2 : p[1] ? 2'h2 : {1'b0, p[0]};
  endfunction : sel
  // three meter windows, so new limits surely apply
  task automatic settle();
    repeat (392) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q, d, m;
    logic [ADDR_W-1:0] a;
    icfo_init_t sv;
    logic [2:0] cd [5];
    cd = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
    q = 8'($urandom(32'h224D));
    repeat (5) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    // reset values, write-only and unmapped reads
    for (int i = 0; i < 5; i++) begin
      a = i == 0 ? A_RTHL : i == 1 ? A_RTHH : i == 2 ? A_SKEW : i == 3 ? A_ATHL : 9'h1FF;
      host.rd(a, q);
      chk(q, i == 1 ? 8'h10 : i == 2 ? 8'h80 : 8'h00, "rst");
    end
    host.gap_max = 2;
    for (int i = 0; i < 8; i++) begin
      a = i == 0 ? A_RHYS : i == 1 ? A_AHYS : i == 7 ? A_SKEW : A_INIT0 + 9'(i - 2);
      d = 8'($urandom);
      host.wr(a, d);
      host.rd(a, q);
      chk(q, d, "rw");
    end
    chk(trim, d, "trim");
    host.gap_max = 0;
    for (int i = 0; i < 10; i++) begin
      dpin = 2'($urandom);
      cpin = 2'($urandom);
      m = {cd[i % 5], 2'h0, cd[(i * 3) % 5]};
      host.wr(A_OMODE, m);
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(drv, sel(m[7:5], dpin), "drv");
      chk(cod, sel(m[2:0], cpin), "cod");
    end
    host.wr(A_SKEW, 8'h11);
    @(posedge sys_clk_i) #1 soft_rst_i = 1'b1;
    @(posedge sys_clk_i) #1 soft_rst_i = 1'b0;
    host.rd(A_OMODE, q);
    chk(q, m, "soft");
    host.rd(A_SKEW, q);
    chk(q, 8'h80, "soft");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'hBE | {1'b0, i[1], 5'h00, i[0]};
      host.ddr_set(d);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk({ddr, dll}, {d[0], d[6]}, "ddr");
    end
    n_short = 0;
    n_odd = 0;
    host.advance();
    repeat (12) @(posedge sys_clk_i);
    host.advance();
    repeat (12) @(posedge sys_clk_i);
    #1;
    chk({n_short, n_odd}, {32'd2, 32'd0}, "oclk");
    for (int i = 0; i < N_INIT; i++) begin
      sv[i] = 8'($urandom);
      host.wr(A_INIT0 + 9'(i), sv[i]);
    end
    corr_run_i = 1'b1;
    for (int k = 0; k < 4 && ild !== 1'b1; k++) @(posedge sys_clk_i) #1;
    chk({ild, ival}, {1'b1, sv}, "init");
    // meters: DC below threshold, then the exact hysteresis boundary
    samp_a = 8'h0F;
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h1C, "dc");
    host.rd(A_STAT, q);
    chk(q, 8'h03, "stat");
    host.wr(A_RHYS, 8'h01);
    samp_a = 8'h10;
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h1C, "hys");
    host.wr(A_RHYS, 8'h00);
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h0E, "rel");
    host.wr(A_RTHL, 8'h00);
    host.wr(A_RTHH, 8'h00);
    smode = 1'b1;
    samp_a = 8'h08;
    host.ac_thr(16'h1001);
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h0E, "ac");
    // dc input keeps the ac meter held while the limit pair is half written
    smode = 1'b0;
    host.ac_thr(16'h0FFF);
    host.wr(A_AHYS, 8'h02);
    smode = 1'b1;
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h0E, "achys");
    host.wr(A_AHYS, 8'h01);
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h07, "acrel");
    host.wr(A_IDX, 8'h00);
    host.wr(A_ATHH, 8'hFF);
    settle();
    chk({rms_h, ac_h, offs, gain, skew}, 5'h07, "noidx");
    results();
  end
endmodule : icfo_regs_tb

// ---- hw/icfo_pkg.sv ----
// icfo_pkg: shared map, field layout and types of the freeze/output config bank
package icfo_pkg;

  // address map (9-bit register space)
  localparam int ADDR_W = 9;
  localparam logic [ADDR_W-1:0] A_IDX      = 9'h010;
  localparam logic [ADDR_W-1:0] A_STAT     = 9'h030;
  localparam logic [ADDR_W-1:0] A_RTHL     = 9'h050;
  localparam logic [ADDR_W-1:0] A_RTHH     = 9'h051;
  localparam logic [ADDR_W-1:0] A_RHYS     = 9'h052;
  localparam logic [ADDR_W-1:0] A_AHYS     = 9'h055;
  localparam logic [ADDR_W-1:0] A_INIT0    = 9'h060;
  localparam logic [ADDR_W-1:0] A_INIT_END = 9'h064;
  localparam logic [ADDR_W-1:0] A_SKEW     = 9'h070;
  localparam logic [ADDR_W-1:0] A_SLIP     = 9'h071;
  localparam logic [ADDR_W-1:0] A_OMODE    = 9'h073;
  localparam logic [ADDR_W-1:0] A_DDR      = 9'h074;
  localparam logic [ADDR_W-1:0] A_CFGS     = 9'h075;
  localparam logic [ADDR_W-1:0] A_ATHL     = 9'h14F;
  localparam logic [ADDR_W-1:0] A_ATHH     = 9'h150;
  localparam logic [7:0]        IDX_AC     = 8'h80;
  localparam int                N_INIT     = 5;

  // reset values
  localparam logic [15:0] RST_RTH  = 16'h1000;
  localparam logic [15:0] RST_ATH  = 16'h1000;
  localparam logic [7:0]  RST_HYS  = 8'h00;
  localparam logic [7:0]  RST_SKEW = 8'h80;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // field layout
  localparam int         FLD_LSB   = 4;
  localparam int         SLIP_BIT  = 0;
  localparam int         DDR_BIT   = 0;
  localparam int         DLL_BIT   = 6;
  localparam logic [7:0] CFGS_MASK = 8'h40;
  localparam int         DRV_LO    = 5;
  localparam int         COD_LO    = 0;
  localparam logic [2:0] SEL_PIN   = 3'h0;
  localparam logic [2:0] SEL_A     = 3'h1;
  localparam logic [2:0] SEL_B     = 3'h2;
  localparam logic [2:0] SEL_C     = 3'h4;
  localparam logic [1:0] PIN_LOW   = 2'h0;
  localparam logic [1:0] PIN_MID   = 2'h1;

  // datapath widths and meter window
  localparam int SAMP_W    = 12;
  localparam int RES_W     = 8;
  localparam int PWR_W     = 24;
  localparam int AVG_SHIFT = 7;
  localparam int ACC_W     = PWR_W + AVG_SHIFT;
  localparam int OCNT_W    = 2;

  // types
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } icfo_req_t;
  typedef logic [N_INIT-1:0][7:0] icfo_init_t;
  typedef enum logic [1:0] {DRV_LVDS_2MA, DRV_LVDS_3MA, DRV_LVCMOS} icfo_drive_t;
  typedef enum logic [1:0] {COD_TWOS, COD_GRAY, COD_OFFSET} icfo_coding_t;
  typedef enum logic {MTR_TRACK, MTR_HOLD} icfo_mtr_t;

endpackage : icfo_pkg

// ---- hw/icfo_regs.sv ----
// icfo_regs: freeze meters, correction start values, skew trim, clock and output config
`timescale 1ns/1ps

// How it works
// RULE1: hold when RMS power below 16-bit threshold
// RULE2: samples MSB-aligned to 12 bits, squared
// RULE3: averaged powers compared about every microsecond
// RULE4: threshold placed in bits 19:4
// RULE5: RMS threshold resets to 0x1000
// RULE6: RMS hold stops gain and skew only
// RULE7: RMS hold ends at threshold plus hysteresis
// RULE8: hysteresis placed in bits 11:4
// RULE9: AC power uses high-passed samples
// RULE10: AC threshold written through index 0x80
// RULE11: AC hold stops skew estimate only
// RULE12: AC hold ends at threshold plus hysteresis
// RULE13: start values loaded when correction starts
// RULE14: skew trim byte, resets to mid-scale
// RULE15: output clock divided from sample clock
// RULE16: 0 then 1 advances output clock
// RULE17: drive field overrides pin when nonzero; the code overrides only for one-hot codes 1, 2 and 4, other codes use the pin
// RULE18: coding field overrides pin when nonzero; the code overrides only for one-hot codes 1, 2 and 4, other codes use the pin
// RULE19: drive/coding register survives soft reset
// RULE20: bit 6 selects slow DLL range
// RULE21: DDR and DLL set through two registers
// RULE22: host writes readback XOR desired value
// RULE23: hold freezes adjustments and estimates
// RULE24: status bits 0 and 1 show holds
// RULE25: new limits apply from next interval
module icfo_regs
  import icfo_pkg::*;
(
  // clock and resets
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         soft_rst_i,
  // configuration port
  input  wire icfo_req_t    cfg_req_i,
  output logic [7:0]        cfg_rdata_o,
  output logic              cfg_rvalid_o,
  // sample stream
  input  wire logic         smp_vld_i,
  input  wire logic [RES_W-1:0] smp_i,
  // correction control
  input  wire logic         corr_run_i,
  output logic              offset_upd_en_o,
  output logic              gain_upd_en_o,
  output logic              skew_upd_en_o,
  output logic              rms_hold_o,
  output logic              ac_hold_o,
  output logic              init_load_o,
  output icfo_init_t        init_val_o,
  output logic [7:0]        skew_trim_o,
  // output clock and format
  output logic              out_clk_o,
  input  wire logic [1:0]   drive_select_pin_i,
  input  wire logic [1:0]   coding_select_pin_i,
  output icfo_drive_t       drive_mode_o,
  output icfo_coding_t      coding_o,
  output logic              ddr_en_o,
  output logic              dll_slow_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // write strobe for one address
  function automatic logic hit(input icfo_req_t r, input logic [ADDR_W-1:0] a);
    return r.wr && (r.addr == a);
  endfunction : hit

  // square of a 12-bit signed sample, never negative
  function automatic logic [PWR_W-1:0] sq(input logic signed [SAMP_W-1:0] x);
    logic signed [PWR_W-1:0] p;
    p = x * x;
    return p;
  endfunction : sq

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic             rst_all;          // hard or soft reset
  logic [7:0]       idx_q;            // index register
  logic [7:0]       rthl_q, rthh_q;   // rms threshold bytes
  logic [7:0]       rhys_q, ahys_q;   // hysteresis bytes
  logic [7:0]       athl_q, athh_q;   // ac threshold bytes
  logic [7:0]       skew_q;           // inter-core skew trim
  logic [7:0]       slip_q;           // phase advance register
  logic [7:0]       omode_q;          // drive and coding
  logic [7:0]       ddr_q;            // effective ddr/dll word
  logic [7:0]       init_q [N_INIT];  // correction start values
  icfo_init_t       init_w;           // packed view of start values
  logic [7:0]       stat_w, cfgs_w;   // read-only views
  logic             idx_ok;           // indexed page open
  logic             slip_evt;         // 0 to 1 on the advance bit

  assign rst_all = sys_rst_i | soft_rst_i;
  assign idx_ok  = (idx_q == IDX_AC);
  assign slip_evt = hit(cfg_req_i, A_SLIP) && cfg_req_i.wdata[SLIP_BIT]
                    && !slip_q[SLIP_BIT]; // RULE16

  // threshold and hysteresis bytes
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      {rthh_q, rthl_q} <= RST_RTH; // RULE5
      {athh_q, athl_q} <= RST_ATH;
      rhys_q <= RST_HYS;
      ahys_q <= RST_HYS;
    end else begin
      if (hit(cfg_req_i, A_RTHL)) rthl_q <= cfg_req_i.wdata; // RULE1
      if (hit(cfg_req_i, A_RTHH)) rthh_q <= cfg_req_i.wdata; // RULE1
      if (hit(cfg_req_i, A_RHYS)) rhys_q <= cfg_req_i.wdata;
      if (hit(cfg_req_i, A_AHYS)) ahys_q <= cfg_req_i.wdata;
      // ac bytes only reachable on the indexed page
      if (idx_ok && hit(cfg_req_i, A_ATHH)) athh_q <= cfg_req_i.wdata; // RULE10
      if (idx_ok && hit(cfg_req_i, A_ATHL)) athl_q <= cfg_req_i.wdata; // RULE10
    end
  end

  // index, skew, phase advance and ddr word
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      idx_q  <= RST_BYTE;
      skew_q <= RST_SKEW; // RULE14
      slip_q <= RST_BYTE;
      ddr_q  <= RST_BYTE;
    end else begin
      if (hit(cfg_req_i, A_IDX))  idx_q  <= cfg_req_i.wdata;
      if (hit(cfg_req_i, A_SKEW)) skew_q <= cfg_req_i.wdata; // RULE14
      if (hit(cfg_req_i, A_SLIP)) slip_q <= cfg_req_i.wdata;
      // host sends old^desired, so xor restores the desired word
      if (hit(cfg_req_i, A_DDR))  ddr_q  <= cfg_req_i.wdata ^ ddr_q; // RULE21
    end
  end

  // drive/coding survives soft reset: only the hard reset clears it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) omode_q <= RST_BYTE; // RULE19
    else if (hit(cfg_req_i, A_OMODE)) omode_q <= cfg_req_i.wdata;
  end

  // start value bytes
  genvar gi;
  generate
    for (gi = 0; gi < N_INIT; gi++) begin : g_init
      localparam logic [ADDR_W-1:0] A_ME = A_INIT0 + ADDR_W'(gi);
      always_ff @(posedge sys_clk_i) begin
        if (rst_all) init_q[gi] <= RST_BYTE;
        else if (hit(cfg_req_i, A_ME)) init_q[gi] <= cfg_req_i.wdata;
      end
      assign init_w[gi] = init_q[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rd_d;   // selected read byte
  logic       in_ini; // address inside start value range
  logic [2:0] ini_ix; // start value index

  assign in_ini = (cfg_req_i.addr >= A_INIT0) && (cfg_req_i.addr <= A_INIT_END);
  assign ini_ix = 3'(cfg_req_i.addr - A_INIT0);
  assign stat_w = {6'h00, ac_hold_o, rms_hold_o}; // RULE24
  assign cfgs_w = ddr_q & CFGS_MASK; // RULE20

  // read mux; write-only and unmapped bytes read zero
  always_comb begin
    rd_d = RST_BYTE;
    case (cfg_req_i.addr)
      A_IDX:   rd_d = idx_q;
      A_STAT:  rd_d = stat_w;
      A_RTHL:  rd_d = rthl_q;
      A_RTHH:  rd_d = rthh_q;
      A_RHYS:  rd_d = rhys_q;
      A_AHYS:  rd_d = ahys_q;
      A_SKEW:  rd_d = skew_q;
      A_SLIP:  rd_d = slip_q;
      A_OMODE: rd_d = omode_q;
      // the pair xors back to the effective word
      A_DDR:   rd_d = ddr_q ^ cfgs_w; // RULE22
      A_CFGS:  rd_d = cfgs_w; // RULE22
      default: rd_d = RST_BYTE;
    endcase
    if (in_ini) begin
      rd_d = init_q[ini_ix];
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o  <= RST_BYTE;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_req_i.rd;
      if (cfg_req_i.rd) cfg_rdata_o <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample conditioning

  logic signed [SAMP_W-1:0] smp_q;  // aligned sample
  logic signed [SAMP_W-1:0] prev_q; // previous aligned sample
  logic                     vld_q;  // aligned sample new
  logic signed [SAMP_W:0]   dif_w;  // first difference
  logic signed [SAMP_W-1:0] hp_w;   // saturated high-pass sample
  logic [AVG_SHIFT-1:0]     cnt_q;  // samples in window
  logic                     win_end;
  logic [PWR_W-1:0]         pwr_w [2];

  // low resolution samples sit in the top bits
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      smp_q  <= '0;
      prev_q <= '0;
      vld_q  <= 1'b0;
    end else begin
      vld_q <= smp_vld_i;
      if (smp_vld_i) begin
        smp_q  <= SAMP_W'(smp_i) << (SAMP_W - RES_W); // RULE2
        prev_q <= smp_q;
      end
    end
  end

  // first difference is the cheapest high-pass; saturate so squares stay 24 bits
  assign dif_w = {smp_q[SAMP_W-1], smp_q} - {prev_q[SAMP_W-1], prev_q}; // RULE9
  assign hp_w  = (dif_w[SAMP_W] != dif_w[SAMP_W-1]) ?
                 {dif_w[SAMP_W], {(SAMP_W-1){~dif_w[SAMP_W]}}} : dif_w[SAMP_W-1:0];
  assign pwr_w[0] = sq(smp_q); // RULE2
  assign pwr_w[1] = sq(hp_w); // RULE9

  // window of 2^AVG_SHIFT samples, about 1 us at one sample per clock
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) cnt_q <= '0;
    else if (vld_q) cnt_q <= cnt_q + 1'b1; // RULE3
  end
  assign win_end = vld_q && (&cnt_q); // RULE3

  ////////////////////////////////////////////////////////////////////////////
  // freeze meters: index 0 rms, index 1 ac rms

  logic [PWR_W-1:0] thr_src [2]; // live thresholds
  logic [PWR_W-1:0] hys_src [2]; // live hysteresis
  logic [PWR_W-1:0] thr_w   [2]; // thresholds of this interval
  logic [PWR_W:0]   up_w    [2]; // release level
  logic [PWR_W-1:0] avg_w   [2]; // average at window end
  logic             hold_w  [2]; // meter in hold

  assign thr_src[0] = PWR_W'({rthh_q, rthl_q}) << FLD_LSB; // RULE4
  assign thr_src[1] = PWR_W'({athh_q, athl_q}) << FLD_LSB; // RULE4
  assign hys_src[0] = PWR_W'(rhys_q) << FLD_LSB; // RULE8
  assign hys_src[1] = PWR_W'(ahys_q) << FLD_LSB; // RULE8

  genvar gm;
  generate
    for (gm = 0; gm < 2; gm++) begin : g_mtr
      logic [ACC_W-1:0] acc_q; // power sum
      logic [ACC_W-1:0] sum_w; // sum with this sample
      logic [PWR_W-1:0] thr_q; // snapped threshold
      logic [PWR_W-1:0] hys_q; // snapped hysteresis
      icfo_mtr_t        st_q, st_d;

      assign sum_w = acc_q + ACC_W'(pwr_w[gm]);
      assign avg_w[gm] = sum_w[AVG_SHIFT +: PWR_W]; // RULE3
      assign thr_w[gm] = thr_q;
      assign up_w[gm] = {1'b0, thr_q} + {1'b0, hys_q};
      assign hold_w[gm] = (st_q == MTR_HOLD);

      // accumulate, restart at window end
      always_ff @(posedge sys_clk_i) begin
        if (rst_all) acc_q <= '0;
        else if (vld_q) acc_q <= win_end ? '0 : sum_w; // RULE3
      end

      // limits snapped at each window end; a pair half written across that edge is used for one interval
      always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
          thr_q <= thr_src[gm];
          hys_q <= hys_src[gm];
        end else if (win_end) begin
          thr_q <= thr_src[gm]; // RULE25
          hys_q <= hys_src[gm]; // RULE25
        end
      end

      // track/hold with hysteresis
      always_comb begin
        st_d = st_q;
        unique case (st_q)
          MTR_TRACK: if (win_end && (avg_w[gm] < thr_q)) st_d = MTR_HOLD; // RULE1
          MTR_HOLD:  if (win_end && ({1'b0, avg_w[gm]} >= up_w[gm])) st_d = MTR_TRACK; // RULE7
        endcase
      end

      always_ff @(posedge sys_clk_i) begin
        if (rst_all) st_q <= MTR_TRACK;
        else st_q <= st_d; // RULE12
      end
    end
  endgenerate

  assign rms_hold_o = hold_w[0]; // RULE24
  assign ac_hold_o  = hold_w[1]; // RULE24

  ////////////////////////////////////////////////////////////////////////////
  // estimate gating and start values

  logic run_q; // correction running, last cycle

  // offset keeps tracking in any hold; gain stops on rms; skew on either
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      run_q           <= 1'b0;
      offset_upd_en_o <= 1'b0;
      gain_upd_en_o   <= 1'b0;
      skew_upd_en_o   <= 1'b0;
    end else begin
      run_q           <= corr_run_i;
      offset_upd_en_o <= run_q; // RULE6
      gain_upd_en_o   <= run_q && !hold_w[0]; // RULE23
      skew_upd_en_o   <= run_q && !hold_w[0] && !hold_w[1]; // RULE11
    end
  end

  // start values handed over on the start edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      init_load_o <= 1'b0;
      init_val_o  <= '0;
    end else begin
      init_load_o <= corr_run_i && !run_q; // RULE13
      if (corr_run_i && !run_q) init_val_o <= init_w; // RULE13
    end
  end

  assign skew_trim_o = skew_q; // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // output clock divider

  logic [OCNT_W-1:0] ocnt_q; // divide-by-four phase

  // a double step pulls the next rising edge one input period earlier
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) ocnt_q <= '0;
    else if (slip_evt) ocnt_q <= ocnt_q + OCNT_W'(2); // RULE16
    else ocnt_q <= ocnt_q + 1'b1; // RULE15
  end
  assign out_clk_o = ocnt_q[OCNT_W-1]; // RULE15

  ////////////////////////////////////////////////////////////////////////////
  // output mode selection

  logic [1:0] dpin1_q, dpin2_q; // drive pin synchroniser
  logic [1:0] cpin1_q, cpin2_q; // coding pin synchroniser
  logic [2:0] drv_f, cod_f;     // register fields

  // pins are asynchronous straps: two flops before use
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      {dpin1_q, dpin2_q} <= '0;
      {cpin1_q, cpin2_q} <= '0;
    end else begin
      dpin1_q <= drive_select_pin_i;
      dpin2_q <= dpin1_q;
      cpin1_q <= coding_select_pin_i;
      cpin2_q <= cpin1_q;
    end
  end

  // one-hot field wins; zero or illegal codes fall back to the pin
  function automatic icfo_drive_t drv_dec(input logic [2:0] f, input logic [1:0] p);
    case (f)
      SEL_A:   return DRV_LVDS_2MA;
      SEL_B:   return DRV_LVDS_3MA;
      SEL_C:   return DRV_LVCMOS;
      default: return (p == PIN_LOW) ? DRV_LVDS_2MA :
                      (p == PIN_MID) ? DRV_LVDS_3MA : DRV_LVCMOS;
    endcase
  endfunction : drv_dec

  function automatic icfo_coding_t cod_dec(input logic [2:0] f, input logic [1:0] p);
    case (f)
      SEL_A:   return COD_TWOS;
      SEL_B:   return COD_GRAY;
      SEL_C:   return COD_OFFSET;
      default: return (p == PIN_LOW) ? COD_TWOS :
                      (p == PIN_MID) ? COD_GRAY : COD_OFFSET;
    endcase
  endfunction : cod_dec

  assign drv_f = omode_q[DRV_LO +: 3];
  assign cod_f = omode_q[COD_LO +: 3];

  // registered mode outputs
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      drive_mode_o <= DRV_LVDS_2MA;
      coding_o     <= COD_TWOS;
      ddr_en_o     <= 1'b0;
      dll_slow_o   <= 1'b0;
    end else begin
      drive_mode_o <= drv_dec(drv_f, dpin2_q); // RULE17
      coding_o     <= cod_dec(cod_f, cpin2_q); // RULE18
      ddr_en_o     <= ddr_q[DDR_BIT]; // RULE21
      dll_slow_o   <= ddr_q[DLL_BIT]; // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_close(int m);
    win_end && !soft_rst_i;
  endsequence

  property p_rth_rst;
    $fell(sys_rst_i) |-> ({rthh_q, rthl_q} == RST_RTH) && (skew_trim_o == RST_SKEW);
  endproperty
  a_rth_rst: assert property (p_rth_rst) else $error("reset threshold wrong"); // RULE5

  property p_rms_enter;
    s_close(0) and (!hold_w[0] && (avg_w[0] < thr_w[0])) |=> hold_w[0];
  endproperty
  a_rms_enter: assert property (p_rms_enter) else $error("rms hold missed"); // RULE1

  property p_rms_exit;
    s_close(0) and (hold_w[0] && ({1'b0, avg_w[0]} >= up_w[0])) |=> !hold_w[0];
  endproperty
  a_rms_exit: assert property (p_rms_exit) else $error("rms release missed"); // RULE7

  property p_ac_exit;
    s_close(1) and (hold_w[1] && ({1'b0, avg_w[1]} < up_w[1])) |=> hold_w[1];
  endproperty
  a_ac_exit: assert property (p_ac_exit) else $error("ac released early"); // RULE12

  property p_gain_frz;
    hold_w[0] && run_q && !soft_rst_i |=> !gain_upd_en_o && !skew_upd_en_o && offset_upd_en_o;
  endproperty
  a_gain_frz: assert property (p_gain_frz) else $error("rms hold gating wrong"); // RULE6

  property p_skew_frz;
    !hold_w[0] && hold_w[1] && run_q && !soft_rst_i |=> !skew_upd_en_o && gain_upd_en_o;
  endproperty
  a_skew_frz: assert property (p_skew_frz) else $error("ac hold gating wrong"); // RULE11

  property p_slip;
    slip_evt && !soft_rst_i |=> ocnt_q == OCNT_W'($past(ocnt_q) + OCNT_W'(2));
  endproperty
  a_slip: assert property (p_slip) else $error("phase advance missed"); // RULE16

  property p_keep_mode;
    soft_rst_i && !hit(cfg_req_i, A_OMODE) |=> $stable(omode_q);
  endproperty
  a_keep_mode: assert property (p_keep_mode) else $error("mode lost on soft reset"); // RULE19

  property p_ddr_xor;
    hit(cfg_req_i, A_DDR) && !soft_rst_i |=> ##1 ddr_en_o == ($past(ddr_q[DDR_BIT], 2)
      ^ $past(cfg_req_i.wdata[DDR_BIT], 2));
  endproperty
  a_ddr_xor: assert property (p_ddr_xor) else $error("ddr word wrong"); // RULE21

  property p_init;
    corr_run_i && !run_q && !soft_rst_i |=> init_load_o && (init_val_o == $past(init_w));
  endproperty
  a_init: assert property (p_init) else $error("start values not loaded"); // RULE13

endmodule : icfo_regs
